//--- common/out_clk_pkg.sv
package out_clk_pkg;
  // Bus shape
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int IDX_W = 10;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG1 = 10'h200;
  localparam logic [IDX_W-1:0] IDX_CFG2 = 10'h201;
  localparam logic [IDX_W-1:0] IDX_DRIVER_REGULATOR_SETTING = 10'h203;
  localparam logic [IDX_W-1:0] IDX_CFG3 = 10'h204;
  localparam logic [IDX_W-1:0] IDX_DIV1 = 10'h205;
  localparam logic [IDX_W-1:0] IDX_DIV2 = 10'h206;
  localparam logic [IDX_W-1:0] IDX_DIV3 = 10'h207;
  localparam logic [IDX_W-1:0] IDX_DUTY = 10'h208;
  localparam logic [IDX_W-1:0] IDX_PHASE = 10'h209;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h20b;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h20c;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h20d;

  // Reset values
  localparam logic [7:0] RST_CFG1 = 8'h00;
  localparam logic [7:0] RST_CFG2 = 8'h00;
  localparam logic [7:0] RST_DRIVER_REGULATOR_SETTING = 8'h00;
  localparam logic [7:0] RST_CFG3 = 8'h00;
  localparam logic [7:0] RST_DIV = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;

  // Writable bits of each register; the rest read as zero
  localparam logic [7:0] MASK_CFG2 = 8'h7f;
  localparam logic [7:0] MASK_DRIVER_REGULATOR_SETTING = 8'h0f;
  localparam logic [7:0] MASK_CFG3 = 8'hb1;
  localparam logic [7:0] MASK_PHASE = 8'h0f;

  // Field positions
  localparam int CFG1_MEDIUM_DIVIDER_VALUE_LSB = 0;
  localparam int MS_W = 7;
  localparam int CFG2_POL = 6;
  localparam int CFG2_FMT_LSB = 0;
  localparam int CFG3_STATUS_EN = 7;
  localparam int CFG3_NEG_SRC = 5;
  localparam int CFG3_SLOW_SEL = 4;
  localparam int CFG3_DIV_TOP = 0;
  localparam int LS_W = 25;
  localparam int STAT_LIVE = 0;
  localparam int STAT_LATCHED = 1;
  localparam int IRQ_SLOW_PERIOD = 0;
  localparam int IRQ_APPLIED = 1;

  // Signal format codes
  localparam logic [3:0] FMT_OFF = 4'h0;
  localparam logic [3:0] FMT_TWO_SAME = 4'h4;
  localparam logic [3:0] FMT_POS_ONLY = 4'h5;
  localparam logic [3:0] FMT_NEG_ONLY = 4'h6;
  localparam logic [3:0] FMT_TWO_INV = 4'h7;

  // Phase line: one tap is half a bank source cycle
  localparam int PHASE_TAPS = 16;
  localparam logic [3:0] PHASE_NOMINAL = 4'h8;
  localparam logic [LS_W-1:0] LS_DUTY_MIN = 25'h0000001;
endpackage

//--- rtl/div_count.sv
`timescale 1ns/1ps
module div_count #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic step,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count,
  output logic wrap
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } cnt_state_t;

  cnt_state_t st_ff, nxt_st;

  // Compare with >= so a lowered limit cannot strand the count
  assign wrap = step && (st_ff.cnt >= limit);
  assign count = st_ff.cnt;

  always_comb begin
    nxt_st = st_ff;
    if (step) begin
      nxt_st.cnt = wrap ? '0 : st_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  a_count_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    wrap |=> count == '0) else $error("divider count did not restart after wrap");
endmodule

//--- rtl/output_clock_lowspeed_divider.sv
`timescale 1ns/1ps
// Notes on behaviour
// RULE1: Status enable gates live and latched slow flags.
// RULE2: Negative pin source: same clock or slow divider.
// RULE3: Software sets slow negative source only in two-CMOS.
// RULE4: Output select: medium divider or slow divider.
// RULE5: Output select needs nonzero medium divider value.
// RULE6: Slow divider value is 25 bits over four registers.
// RULE7: Slow divider divides medium clock by value plus one.
// RULE8: Slow divider idle when medium divider value zero.
// RULE9: Duty control needs medium nonzero, slow above one.
// RULE10: Zero duty field gives fifty percent duty.
// RULE11: Nonzero duty is pulse of that many medium periods.
// RULE12: Inversion off: high pulse; on: low pulse.
// RULE13: Phase codes 0 to 7 lag by half steps.
// RULE14: Phase codes 8 to 15 lead per fixed table.
// RULE15: Negative phase leads, positive phase lags.
// RULE16: Medium divides by value plus one; zero bypasses.
// RULE17: Inversion never touches slow negative pin path.
// RULE18: New divider settings apply at period boundary.
module output_clock_lowspeed_divider (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [out_clk_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [out_clk_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [out_clk_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic irq,
  output logic positive_output_pin,
  output logic negative_output_pin
);
  import out_clk_pkg::*;

  typedef struct packed {
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] driver_regulator_setting;
    logic [7:0] cfg3;
    logic [7:0] div1;
    logic [7:0] div2;
    logic [7:0] div3;
    logic [7:0] duty;
    logic [7:0] phase;
    logic [MS_W-1:0] act_medium_divider_value;
    logic [LS_W-1:0] act_slow_divider_value;
    logic [7:0] act_duty;
    logic [3:0] act_phase;
    logic pend;
    logic bank;
    logic live;
    logic latched;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic pos;
    logic neg;
    logic [3:0] tap_age;
    logic [3:0] tap_last;
  } state_t;

  state_t st_ff, nxt_st;

  logic [IDX_W-1:0] idx;
  logic req;
  logic ms_on;
  logic [MS_W-1:0] ms_cnt;
  logic ms_wrap;
  logic [LS_W-1:0] ls_cnt;
  logic ls_wrap;
  logic ms_lvl;
  logic half_lvl;
  logic duty_on;
  logic slow_lvl;
  logic sel_lvl;
  logic pos_clk;
  logic neg_clk;
  logic pos_raw;
  logic neg_raw;
  logic [3:0] fmt;
  logic [3:0] tap;
  logic [1:0] line_out;
  logic boundary;
  logic [LS_W-1:0] cfg_slow_divider_value;
  logic [7:0] rd_byte;
  logic [1:0] irq_ev;
  logic [1:0] irq_clr;
  logic latch_clr;
  logic pend_set;

  function automatic logic [3:0] phase_tap(input logic [3:0] code);
    if (!code[3]) begin
      phase_tap = PHASE_NOMINAL + code;
    end else begin
      phase_tap = PHASE_NOMINAL - ({1'b0, code[2:1], 1'b0} + 4'h2) + {3'h0, code[0]};
    end
  endfunction

  assign idx = address[ADDR_W-1:2];
  assign req = read || write;
  assign fmt = st_ff.cfg2[CFG2_FMT_LSB +: 4];
  assign ms_on = st_ff.act_medium_divider_value != '0; // RULE16
  assign cfg_slow_divider_value = {st_ff.cfg3[CFG3_DIV_TOP], st_ff.div3, st_ff.div2, st_ff.div1}; // RULE6

  // Bank source clock is half the core rate; medium divider steps once per bank cycle
  div_count #(.W(MS_W)) u_ms_div (
    .clk(clk),
    .rst_n(rst_n),
    .step(st_ff.bank && ms_on), // RULE16
    .limit(st_ff.act_medium_divider_value),
    .count(ms_cnt),
    .wrap(ms_wrap)
  );

  div_count #(.W(LS_W)) u_ls_div (
    .clk(clk),
    .rst_n(rst_n),
    .step(ms_wrap), // RULE7 RULE8
    .limit(st_ff.act_slow_divider_value),
    .count(ls_cnt),
    .wrap(ls_wrap)
  );

  always_comb begin
    ms_lvl = {1'b0, ms_cnt, 1'b0} < ({2'h0, st_ff.act_medium_divider_value} + 9'h001);
    half_lvl = {1'b0, ls_cnt, 1'b0} < ({2'h0, st_ff.act_slow_divider_value} + 27'h0000001); // RULE10
    duty_on = ms_on && (st_ff.act_slow_divider_value > LS_DUTY_MIN) && (st_ff.act_duty != 8'h00); // RULE9
    slow_lvl = ms_on && (duty_on ? (ls_cnt < {17'h00000, st_ff.act_duty}) : half_lvl); // RULE11
    if (!ms_on) begin
      sel_lvl = st_ff.bank; // RULE16
    end else begin
      sel_lvl = st_ff.cfg3[CFG3_SLOW_SEL] ? slow_lvl : ms_lvl; // RULE4 RULE5
    end
    pos_clk = sel_lvl ^ st_ff.cfg2[CFG2_POL]; // RULE12
    if (st_ff.cfg3[CFG3_NEG_SRC]) begin
      neg_clk = slow_lvl; // RULE2 RULE17
    end else begin
      neg_clk = (fmt == FMT_TWO_INV) ? ~pos_clk : pos_clk;
    end
    pos_raw = (fmt == FMT_OFF || fmt == FMT_NEG_ONLY) ? 1'b0 : pos_clk;
    neg_raw = (fmt == FMT_OFF || fmt == FMT_POS_ONLY) ? 1'b0 : neg_clk;
    tap = ms_on ? phase_tap(st_ff.act_phase) : PHASE_NOMINAL; // RULE13 RULE14 RULE15
    if (!ms_on) begin
      boundary = 1'b1;
    end else begin
      boundary = st_ff.cfg3[CFG3_SLOW_SEL] ? ls_wrap : ms_wrap; // RULE18
    end
  end

  // Every output sits at a nominal eight-tap delay so a code can move it either way
  tap_delay #(.W(2), .N(PHASE_TAPS)) u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .din({pos_raw, neg_raw}),
    .tap(tap),
    .dout(line_out)
  );

  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      IDX_CFG1: rd_byte = st_ff.cfg1;
      IDX_CFG2: rd_byte = st_ff.cfg2;
      IDX_DRIVER_REGULATOR_SETTING: rd_byte = st_ff.driver_regulator_setting;
      IDX_CFG3: rd_byte = st_ff.cfg3;
      IDX_DIV1: rd_byte = st_ff.div1;
      IDX_DIV2: rd_byte = st_ff.div2;
      IDX_DIV3: rd_byte = st_ff.div3;
      IDX_DUTY: rd_byte = st_ff.duty;
      IDX_PHASE: rd_byte = st_ff.phase;
      IDX_STATUS: begin
        rd_byte[STAT_LIVE] = st_ff.live;
        rd_byte[STAT_LATCHED] = st_ff.latched && st_ff.cfg3[CFG3_STATUS_EN]; // RULE1
      end
      IDX_IRQ_STAT: rd_byte = {6'h00, st_ff.irq_stat};
      IDX_IRQ_MASK: rd_byte = {6'h00, st_ff.irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    irq_clr = 2'h0;
    latch_clr = 1'b0;
    pend_set = 1'b0;
    nxt_st.bank = ~st_ff.bank;
    // Request is answered one cycle after it is seen; it commits at the low-waitrequest edge
    if (req && st_ff.waitreq) begin
      nxt_st.waitreq = 1'b0;
      nxt_st.rdata = read ? {24'h000000, rd_byte} : '0;
    end else if (req) begin
      nxt_st.waitreq = 1'b1;
      if (read && idx == IDX_STATUS) begin
        latch_clr = 1'b1;
      end
      if (read && idx == IDX_IRQ_STAT) begin
        irq_clr = 2'h3;
      end
      if (write && byteenable[0]) begin
        unique case (idx)
          IDX_CFG1: nxt_st.cfg1 = writedata[7:0];
          IDX_CFG2: nxt_st.cfg2 = writedata[7:0] & MASK_CFG2;
          IDX_DRIVER_REGULATOR_SETTING: nxt_st.driver_regulator_setting = writedata[7:0] & MASK_DRIVER_REGULATOR_SETTING;
          IDX_CFG3: nxt_st.cfg3 = writedata[7:0] & MASK_CFG3;
          IDX_DIV1: nxt_st.div1 = writedata[7:0];
          IDX_DIV2: nxt_st.div2 = writedata[7:0];
          IDX_DIV3: nxt_st.div3 = writedata[7:0];
          IDX_DUTY: nxt_st.duty = writedata[7:0];
          IDX_PHASE: nxt_st.phase = writedata[7:0] & MASK_PHASE;
          IDX_IRQ_MASK: nxt_st.irq_mask = writedata[1:0];
          default: nxt_st.irq_mask = st_ff.irq_mask;
        endcase
        if (idx == IDX_CFG1 || idx == IDX_CFG3 || (idx >= IDX_DIV1 && idx <= IDX_PHASE)) begin
          pend_set = 1'b1;
        end
      end
    end
    // Live settings change at the end of an output period, avoiding runt pulses; with the medium divider bypassed they apply on any cycle
    if (boundary) begin
      nxt_st.act_medium_divider_value = st_ff.cfg1[CFG1_MEDIUM_DIVIDER_VALUE_LSB +: MS_W]; // RULE18
      nxt_st.act_slow_divider_value = cfg_slow_divider_value;
      nxt_st.act_duty = st_ff.duty;
      nxt_st.act_phase = st_ff.phase[3:0];
      nxt_st.pend = 1'b0;
    end
    // A fresh write stays pending past a boundary in the same cycle; it applies at the next one
    if (pend_set) begin
      nxt_st.pend = 1'b1;
    end
    nxt_st.live = st_ff.cfg3[CFG3_STATUS_EN] && slow_lvl; // RULE1
    nxt_st.latched = (st_ff.latched && !latch_clr) || nxt_st.live; // RULE1
    irq_ev = 2'h0;
    irq_ev[IRQ_SLOW_PERIOD] = ls_wrap;
    irq_ev[IRQ_APPLIED] = boundary && st_ff.pend;
    nxt_st.irq_stat = (st_ff.irq_stat & ~irq_clr) | irq_ev;
    nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_mask);
    nxt_st.pos = line_out[1];
    nxt_st.neg = line_out[0];
    nxt_st.tap_last = tap;
    if (tap != st_ff.tap_last) begin
      nxt_st.tap_age = 4'h0;
    end else if (st_ff.tap_age != 4'hf) begin
      nxt_st.tap_age = st_ff.tap_age + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.waitreq <= 1'b1;
      st_ff.cfg1 <= RST_CFG1;
      st_ff.cfg2 <= RST_CFG2;
      st_ff.driver_regulator_setting <= RST_DRIVER_REGULATOR_SETTING;
      st_ff.cfg3 <= RST_CFG3;
      st_ff.div1 <= RST_DIV;
      st_ff.div2 <= RST_DIV;
      st_ff.div3 <= RST_DIV;
      st_ff.duty <= RST_DUTY;
      st_ff.phase <= RST_PHASE;
      st_ff.irq_mask <= RST_IRQ_MASK;
      st_ff.tap_last <= PHASE_NOMINAL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.waitreq;
  assign irq = st_ff.irq;
  assign positive_output_pin = st_ff.pos;
  assign negative_output_pin = st_ff.neg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_settings_moved;
    $changed(st_ff.act_slow_divider_value) || $changed(st_ff.act_duty) || $changed(st_ff.act_phase);
  endsequence

  property p_apply_on_edge;
    s_settings_moved |-> $past(boundary);
  endproperty

  a_status_gate: assert property ( // RULE1
    !$past(st_ff.cfg3[CFG3_STATUS_EN]) |-> !st_ff.live)
    else $error("live slow flag set while status disabled");
  a_neg_slow_pin: assert property ( // RULE2
    (st_ff.tap_age >= 4'hb && tap == PHASE_NOMINAL && $past(st_ff.cfg3[CFG3_NEG_SRC], 10)
      && $past(fmt, 10) == FMT_TWO_SAME) |-> st_ff.neg == $past(slow_lvl, 10))
    else $error("negative pin does not carry slow clock");
  a_slow_select: assert property ( // RULE4
    (ms_on && st_ff.cfg3[CFG3_SLOW_SEL] && !st_ff.cfg2[CFG2_POL]) |-> ##0 pos_clk == slow_lvl)
    else $error("slow select did not route slow divider");
  a_slow_wrap: assert property ( // RULE7
    ls_wrap |-> ms_wrap && ls_cnt >= st_ff.act_slow_divider_value)
    else $error("slow divider wrapped off its period");
  a_slow_idle: assert property ( // RULE8
    !ms_on |-> !ls_wrap && !slow_lvl)
    else $error("slow divider active with medium bypass");
  a_duty_pulse: assert property ( // RULE11
    duty_on |-> slow_lvl == (ls_cnt < {17'h00000, st_ff.act_duty}))
    else $error("duty pulse level wrong");
  a_half_duty: assert property ( // RULE10
    (ms_on && st_ff.act_duty == 8'h00 && ls_cnt == 25'h0000000) |-> slow_lvl)
    else $error("fifty percent slow clock not high at start");
  a_lead_tap: assert property ( // RULE14
    (ms_on && st_ff.act_phase == 4'he) |-> tap == 4'h0)
    else $error("largest lead code not at first tap");
  a_phase_lag: assert property ( // RULE13
    (st_ff.tap_age >= 4'hb && tap == PHASE_NOMINAL) |-> st_ff.pos == $past(pos_raw, 10))
    else $error("nominal phase delay is not ten cycles");
  a_phase_lead: assert property ( // RULE15
    (st_ff.tap_age >= 4'h4 && tap == 4'h0) |-> st_ff.pos == $past(pos_raw, 2))
    else $error("leading phase delay is not two cycles");
  a_bypass_path: assert property ( // RULE16
    (!ms_on && st_ff.cfg2[CFG2_FMT_LSB +: 4] == FMT_TWO_SAME && !st_ff.cfg2[CFG2_POL])
      |-> pos_raw == st_ff.bank && tap == PHASE_NOMINAL)
    else $error("bypass does not pass bank clock");
  a_apply_edge: assert property (p_apply_on_edge) // RULE18
    else $error("settings changed away from a period boundary");
endmodule

//--- rtl/tap_delay.sv
`timescale 1ns/1ps
module tap_delay #(
  parameter int W = 2,
  parameter int N = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  input wire logic [$clog2(N)-1:0] tap,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [N-1:0][W-1:0] line;
  } line_state_t;

  line_state_t st_ff, nxt_st;

  assign dout = st_ff.line[tap];

  always_comb begin
    nxt_st = st_ff;
    nxt_st.line[0] = din;
    for (int k = 1; k < N; k++) begin
      nxt_st.line[k] = st_ff.line[k-1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

//--- testbench/output_clock_lowspeed_divider_tb.sv
`timescale 1ns/1ps
module output_clock_lowspeed_divider_tb;
  import out_clk_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic [3:0] byteenable = 4'h1;
  logic [DATA_W-1:0] readdata;
  logic waitrequest, irq, positive_output_pin, negative_output_pin;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [DATA_W-1:0] d;

  output_clock_lowspeed_divider i_dut (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .positive_output_pin(positive_output_pin),
    .negative_output_pin(negative_output_pin)
  );

  always #25 clk = ~clk;

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard: whole sequence needs well under this many cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      $display("ERROR at %0t: timeout", $time);
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  // One Avalon transfer; request held until waitrequest is sampled low
  task automatic xfer(input logic rw, input logic [IDX_W-1:0] idx, input logic [7:0] wd,
                      output logic [DATA_W-1:0] rd);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {24'h000000, wd};
    write <= rw;
    read <= ~rw;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    if (!rw) chk(rd[31:8], 32'h0, "readdata upper bits");
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] wd);
    logic [DATA_W-1:0] x;
    xfer(1'b1, idx, wd, x);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, output logic [DATA_W-1:0] v);
    xfer(1'b0, idx, 8'h00, v);
  endtask

  function automatic logic pinv(input bit neg);
    return neg ? negative_output_pin : positive_output_pin;
  endfunction

  // Measures one period and its high time in clk cycles
  task automatic meas(input bit neg, output int per, output int hi);
    int n;
    n = 0;
    hi = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pinv(neg) !== 1'b0 && n < 300);
    do begin
      @(posedge clk);
      n++;
    end while (pinv(neg) !== 1'b1 && n < 600);
    do begin
      @(posedge clk);
      hi++;
    end while (pinv(neg) === 1'b1 && hi < 300);
    per = hi;
    do begin
      @(posedge clk);
      per++;
    end while (pinv(neg) === 1'b0 && per < 600);
  endtask

  // Lets new settings reach a period boundary, then checks the waveform
  task automatic wave(input bit neg, input int per, input int hi, input string what);
    int p, h;
    meas(neg, p, h);
    meas(neg, p, h);
    meas(neg, p, h);
    chk(p, per, {what, " period"});
    chk(h, hi, {what, " high"});
  endtask

  localparam logic [IDX_W-1:0] RW_IDX [10] = '{IDX_CFG1, IDX_CFG2, IDX_DRIVER_REGULATOR_SETTING, IDX_CFG3,
    IDX_DIV1, IDX_DIV2, IDX_DIV3, IDX_DUTY, IDX_PHASE, IDX_IRQ_MASK};
  localparam logic [7:0] RW_MASK [10] = '{8'hff, MASK_CFG2, MASK_DRIVER_REGULATOR_SETTING, MASK_CFG3,
    8'hff, 8'hff, 8'hff, 8'hff, MASK_PHASE, 8'h03};
  localparam int HALF_STEPS [16] = '{0, 1, 2, 3, 4, 5, 6, 7, -2, -1, -4, -3, -6, -5, -8, -7};

  initial begin
    int t0, base, rel, n;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // Register reset values and writable bits
    for (int i = 0; i < 10; i++) begin
      rd(RW_IDX[i], d);
      chk(d, 32'h0, "reset value");
      wr(RW_IDX[i], 8'hff);
      rd(RW_IDX[i], d);
      chk(d, {24'h0, RW_MASK[i]}, "readback");
    end
    wr(10'h20a, 8'hff);
    rd(10'h20a, d);
    chk(d, 32'h0, "unmapped read");
    // Bypass: bank clock straight through, slow path silent
    do_reset();
    wr(IDX_CFG2, 8'h04);
    wr(IDX_CFG3, 8'h30);
    wave(1'b0, 2, 1, "bypass");
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (negative_output_pin !== 1'b0) n++;
    end
    chk(n, 0, "slow path idle in bypass");
    // Medium divider by three, odd ratio
    do_reset();
    wr(IDX_CFG2, 8'h04);
    wr(IDX_CFG1, 8'h02);
    wave(1'b0, 6, 4, "medium");
    wr(IDX_DIV1, 8'h02);
    wr(IDX_CFG3, 8'h10);
    wave(1'b0, 18, 12, "slow 50");
    wr(IDX_DIV1, 8'h03);
    wr(IDX_DUTY, 8'h03);
    wave(1'b0, 24, 18, "duty 3");
    wr(IDX_CFG2, 8'h44);
    wave(1'b0, 24, 6, "duty inverted");
    wr(IDX_CFG2, 8'h04);
    wr(IDX_DIV1, 8'h01);
    wave(1'b0, 12, 6, "duty ignored");
    wr(IDX_CFG3, 8'h20);
    wave(1'b0, 6, 4, "pos medium");
    wave(1'b1, 12, 6, "neg slow");
    wr(IDX_CFG3, 8'h00);
    wave(1'b1, 6, 4, "neg same");
    wr(IDX_CFG2, 8'h07);
    wave(1'b1, 6, 2, "neg inverted");
    wr(IDX_CFG2, 8'h04);
    // Slow status gating and latched flag
    for (int i = 0; i < 4; i++) begin
      rd(IDX_STATUS, d);
      chk(d, 32'h0, "status disabled");
    end
    wr(IDX_CFG3, 8'h80);
    repeat (30) @(posedge clk);
    rd(IDX_STATUS, d);
    chk(d[STAT_LATCHED], 1'b1, "latched slow flag");
    wr(IDX_CFG3, 8'h00);
    repeat (4) @(posedge clk);
    rd(IDX_STATUS, d);
    rd(IDX_STATUS, d);
    chk(d, 32'h0, "status gated again");
    // Interrupt: masked, unmasked, cleared by read
    do_reset();
    wr(IDX_DUTY, 8'h05);
    repeat (4) @(posedge clk);
    chk(irq, 1'b0, "irq masked");
    wr(IDX_IRQ_MASK, 8'h02);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1, "irq raised");
    rd(IDX_IRQ_STAT, d);
    chk(d[IRQ_APPLIED], 1'b1, "applied event");
    repeat (3) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
    wr(IDX_CFG2, 8'h04);
    wr(IDX_CFG1, 8'h01);
    wr(IDX_IRQ_MASK, 8'h01);
    repeat (20) @(posedge clk);
    chk(irq, 1'b1, "slow period irq");
    // Phase steps: rise time relative to code 0, modulo the 16-cycle period
    base = 0;
    for (int c = 0; c < 16; c++) begin
      do_reset();
      wr(IDX_PHASE, c[7:0]);
      wr(IDX_CFG1, 8'h07);
      t0 = cyc;
      wr(IDX_CFG2, 8'h04);
      n = 0;
      while (positive_output_pin !== 1'b1 && n < 100) begin
        @(posedge clk);
        n++;
      end
      rel = (cyc - t0) % 16;
      if (c == 0) base = rel;
      chk((rel - base + 16) % 16, (HALF_STEPS[c] + 16) % 16, "phase step");
    end
    summarize();
  end
endmodule
